// file: verilog/dcfpf_defines.vh
// Constants shared by the programmable-flag FIFO files.
// Assumes the 64-word by 18-bit build of the FIFO.
`ifndef DCFPF_DEFINES_VH
`define DCFPF_DEFINES_VH

// ============================================================
// Array shape
`define DCFPF_DATA_W 18
`define DCFPF_ADDR_W 6
`define DCFPF_PTR_W 7
`define DCFPF_DEPTH 7'h40
`define DCFPF_HALF 7'h20

// ============================================================
// Threshold registers and their field on the data ports
`define DCFPF_THR_W 12
`define DCFPF_THR_LSB 0
`define DCFPF_THR_MSB 11
`define DCFPF_AE_THR_RESET 12'h007
`define DCFPF_AF_THR_RESET 12'h007
`define DCFPF_SEL_EMPTY 1'b0
`define DCFPF_SEL_FULL 1'b1

// ============================================================
// Pin synchroniser
`define DCFPF_SYNC_W 28
`define DCFPF_SYNC_RESET 28'h0000000

`endif

// file: verilog/dcfpf_sync2.v
// Two-stage synchroniser for a bundle of pin inputs.
// Assumes every bit is unrelated to clk; no bit is read before stage two.
`timescale 1ns/10ps

module dcfpf_sync2 #(
  parameter W = 28
) (
  input wire clk,
  input wire resetn,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  // ============================================================
  // Stages
  reg [W-1:0] stage1_reg;
  reg [W-1:0] stage2_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1_reg <= {W{1'b0}};
      stage2_reg <= {W{1'b0}};
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule

// file: verilog/dcfpf_top.v
// Programmable-flag FIFO, 64 words of 18 bits, with retransmit.
// Assumes one system clock well above the pin clocks; the write and read
// clocks arrive as pins and are sampled, their rising edges detected.
//
// Notes on behaviour
// - write enable low stores the input word on each write-clock rise.
// - read enable low presents the next word on each read-clock rise.
// - output enable high floats the data outputs, low drives the output register.
// - in a cascade only the read-enabled device drives its outputs.
// - writes are ignored while the full flag is low.
// - reads are ignored while the empty flag is low; read pointer holds.
// - an empty FIFO keeps showing the last valid read word.
// - two 12-bit thresholds load from the low twelve data bits.
// - programming writes alternate empty threshold, full threshold, empty again.
// - load high resumes normal use; next programming write continues the sequence.
// - load and read enable low read thresholds back in the same alternation.
// - full flag low at full depth, changes only on write-clock rises and on retransmit.
// - empty flag low at zero words, changes only on read-clock rises and on retransmit.
// - almost flags low within threshold of the boundary; half flag low above half.
// - flag mode low syncs almost-full to write clock, almost-empty to read clock.
// - unprogrammed thresholds default to 7 for the 64-deep array.
// - a retransmit pulse rewinds the read pointer to location zero, standalone only.
// - after retransmit reads replay data; flags follow the pointers.
// - FIFO reset empties the array and drives the empty flag low.
// - the half-full output carries the half-full flag in standalone use.
`timescale 1ns/10ps
`include "dcfpf_defines.vh"

module dcfpf_top (
  input wire clk,
  input wire resetn,
  input wire write_clk,
  input wire write_en_n,
  input wire [`DCFPF_DATA_W-1:0] write_data_in,
  input wire read_clk,
  input wire read_en_n,
  input wire output_en_n,
  input wire threshold_load_n,
  input wire replay_pulse,
  input wire sync_flag_mode_n,
  input wire fifo_reset_n,
  input wire depth_cascade_en,
  output wire [`DCFPF_DATA_W-1:0] read_data_out,
  output wire read_data_oe,
  output wire full_flag_n,
  output wire empty_flag_n,
  output wire almost_empty_flag_n,
  output wire almost_full_flag_n,
  output wire half_full_flag_n
);

  // ============================================================
  // Pin synchronisation
  wire [`DCFPF_SYNC_W-1:0] pins_raw;
  wire [`DCFPF_SYNC_W-1:0] pins_sync;

  assign pins_raw = {write_clk, read_clk, write_en_n, read_en_n, output_en_n,
                     threshold_load_n, replay_pulse, sync_flag_mode_n,
                     fifo_reset_n, depth_cascade_en, write_data_in};

  dcfpf_sync2 #(
    .W(`DCFPF_SYNC_W)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  wire wclk_s;
  wire rclk_s;
  wire wen_n_s;
  wire ren_n_s;
  wire oe_n_s;
  wire load_n_s;
  wire replay_s;
  wire sync_flag_mode_n_n_s;
  wire frst_n_s;
  wire cascade_s;
  wire [`DCFPF_DATA_W-1:0] wdata_s;

  assign wclk_s = pins_sync[27];
  assign rclk_s = pins_sync[26];
  assign wen_n_s = pins_sync[25];
  assign ren_n_s = pins_sync[24];
  assign oe_n_s = pins_sync[23];
  assign load_n_s = pins_sync[22];
  assign replay_s = pins_sync[21];
  assign sync_flag_mode_n_n_s = pins_sync[20];
  assign frst_n_s = pins_sync[19];
  assign cascade_s = pins_sync[18];
  assign wdata_s = pins_sync[17:0];

  // ============================================================
  // Edge detection on the sampled pin clocks
  reg wclk_d_reg;
  reg rclk_d_reg;
  reg replay_d_reg;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wclk_d_reg <= 1'b0;
      rclk_d_reg <= 1'b0;
      replay_d_reg <= 1'b0;
    end else begin
      wclk_d_reg <= wclk_s;
      rclk_d_reg <= rclk_s;
      replay_d_reg <= replay_s;
    end
  end

  wire wr_edge;
  wire rd_edge;
  wire replay_edge;

  assign wr_edge = wclk_s & ~wclk_d_reg;
  assign rd_edge = rclk_s & ~rclk_d_reg;
  assign replay_edge = replay_s & ~replay_d_reg;

  // ============================================================
  // State
  reg [`DCFPF_DATA_W-1:0] mem [0:(1<<`DCFPF_ADDR_W)-1];
  reg [`DCFPF_PTR_W-1:0] wr_ptr_reg;
  reg [`DCFPF_PTR_W-1:0] rd_ptr_reg;
  reg [`DCFPF_THR_W-1:0] ae_thr_reg;
  reg [`DCFPF_THR_W-1:0] af_thr_reg;
  reg wsel_reg;
  reg rsel_reg;
  reg [`DCFPF_DATA_W-1:0] read_data_reg;
  reg data_oe_reg;
  reg full_n_reg;
  reg empty_n_reg;
  reg ae_n_reg;
  reg af_n_reg;
  reg hf_n_reg;

  // ============================================================
  // Operation decode
  wire prog_wr;
  wire fifo_wr;
  wire prog_rd;
  wire fifo_rd;
  wire replay_go;

  // Load low steers the clock edge to the thresholds, never the array
  assign prog_wr = wr_edge & ~load_n_s & ~wen_n_s;
  assign fifo_wr = wr_edge & load_n_s & ~wen_n_s & full_n_reg;
  assign prog_rd = rd_edge & ~load_n_s & ~ren_n_s;
  assign fifo_rd = rd_edge & load_n_s & ~ren_n_s & empty_n_reg;
  // Retransmit is meaningless once the read side is split across devices
  assign replay_go = replay_edge & ~cascade_s;

  // ============================================================
  // Pointer and count arithmetic
  reg [`DCFPF_PTR_W-1:0] wr_ptr_next;
  reg [`DCFPF_PTR_W-1:0] rd_ptr_next;
  wire [`DCFPF_PTR_W-1:0] count_next;

  always @* begin
    wr_ptr_next = wr_ptr_reg;
    if (fifo_wr) begin
      wr_ptr_next = wr_ptr_reg + 7'h01;
    end
  end

  always @* begin
    rd_ptr_next = rd_ptr_reg;
    if (replay_go) begin
      rd_ptr_next = 7'h00;
    end else if (fifo_rd) begin
      rd_ptr_next = rd_ptr_reg + 7'h01;
    end
  end

  // One extra pointer bit keeps full (64) distinct from empty (0)
  assign count_next = wr_ptr_next - rd_ptr_next;

  wire [`DCFPF_THR_W:0] af_sum;
  wire ae_hit;
  wire af_hit;
  wire hf_hit;

  assign af_sum = {6'h00, count_next} + {1'b0, af_thr_reg};
  assign ae_hit = {5'h00, count_next} <= ae_thr_reg;
  assign af_hit = af_sum >= {6'h00, `DCFPF_DEPTH};
  assign hf_hit = count_next > `DCFPF_HALF;

  // ============================================================
  // Storage array
  // No reset on the array: contents are don't-care until written
  always @(posedge clk) begin
    if (fifo_wr) begin
      mem[wr_ptr_reg[`DCFPF_ADDR_W-1:0]] <= wdata_s;
    end
  end

  // ============================================================
  // Pointers
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= 7'h00;
      rd_ptr_reg <= 7'h00;
    end else if (!frst_n_s) begin
      wr_ptr_reg <= 7'h00;
      rd_ptr_reg <= 7'h00;
    end else begin
      // Threshold traffic is excluded from both next-pointer terms
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // ============================================================
  // Threshold registers and their alternating selectors
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ae_thr_reg <= `DCFPF_AE_THR_RESET;
      af_thr_reg <= `DCFPF_AF_THR_RESET;
      wsel_reg <= `DCFPF_SEL_EMPTY;
    end else if (!frst_n_s) begin
      ae_thr_reg <= `DCFPF_AE_THR_RESET;
      af_thr_reg <= `DCFPF_AF_THR_RESET;
      wsel_reg <= `DCFPF_SEL_EMPTY;
    end else if (prog_wr) begin
      if (wsel_reg == `DCFPF_SEL_EMPTY) begin
        ae_thr_reg <= wdata_s[`DCFPF_THR_MSB:`DCFPF_THR_LSB];
      end else begin
        af_thr_reg <= wdata_s[`DCFPF_THR_MSB:`DCFPF_THR_LSB];
      end
      // Selector survives load going high, so a later write continues
      wsel_reg <= ~wsel_reg;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rsel_reg <= `DCFPF_SEL_EMPTY;
    end else if (!frst_n_s) begin
      rsel_reg <= `DCFPF_SEL_EMPTY;
    end else if (prog_rd) begin
      rsel_reg <= ~rsel_reg;
    end
  end

  // ============================================================
  // Output register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      read_data_reg <= 18'h00000;
    end else if (!frst_n_s) begin
      read_data_reg <= 18'h00000;
    end else if (prog_rd) begin
      if (rsel_reg == `DCFPF_SEL_EMPTY) begin
        read_data_reg <= {6'h00, ae_thr_reg};
      end else begin
        read_data_reg <= {6'h00, af_thr_reg};
      end
    end else if (fifo_rd) begin
      read_data_reg <= mem[rd_ptr_reg[`DCFPF_ADDR_W-1:0]];
    end
    // With the FIFO empty and load high no branch fires, so the last word stays
  end

  // Enable is registered so it lines up with the sampled control pins
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_oe_reg <= 1'b0;
    end else begin
      data_oe_reg <= ~oe_n_s & (~cascade_s | ~ren_n_s);
    end
  end

  // ============================================================
  // Boundary flags
  // Each flag only moves on its own clock edge or a retransmit, so a stale flag is always
  // conservative: full may lag a read, empty may lag a write.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      full_n_reg <= 1'b1;
    end else if (!frst_n_s) begin
      full_n_reg <= 1'b1;
    end else if (wr_edge | replay_go) begin
      full_n_reg <= ~(count_next == `DCFPF_DEPTH);
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      empty_n_reg <= 1'b0;
    end else if (!frst_n_s) begin
      empty_n_reg <= 1'b0;
    end else if (rd_edge | replay_go) begin
      empty_n_reg <= (count_next != 7'h00);
    end
  end

  // ============================================================
  // Programmable and half flags
  wire af_update;
  wire ae_update;

  // Flag mode high lets the almost flags follow the count on every cycle
  assign af_update = sync_flag_mode_n_n_s | wr_edge | replay_go;
  assign ae_update = sync_flag_mode_n_n_s | rd_edge | replay_go;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      af_n_reg <= 1'b1;
      ae_n_reg <= 1'b0;
    end else if (!frst_n_s) begin
      af_n_reg <= 1'b1;
      ae_n_reg <= 1'b0;
    end else begin
      if (af_update) begin
        af_n_reg <= ~af_hit;
      end
      if (ae_update) begin
        ae_n_reg <= ~ae_hit;
      end
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hf_n_reg <= 1'b1;
    end else if (!frst_n_s) begin
      hf_n_reg <= 1'b1;
    end else begin
      hf_n_reg <= ~hf_hit;
    end
  end

  // ============================================================
  // Outputs
  assign read_data_out = read_data_reg;
  assign read_data_oe = data_oe_reg;
  assign full_flag_n = full_n_reg;
  assign empty_flag_n = empty_n_reg;
  assign almost_empty_flag_n = ae_n_reg;
  assign almost_full_flag_n = af_n_reg;
  assign half_full_flag_n = hf_n_reg;

endmodule

// file: bench/dcfpf_checker_assertions.sv
// Pin-level checks on the programmable-flag FIFO.
// Assumes both pin clocks pulse together, each phase at least three clk.
`timescale 1ns/10ps
`include "dcfpf_defines.vh"

module dcfpf_checker (
  input wire clk,
  input wire resetn,
  input wire write_clk,
  input wire read_clk,
  input wire read_en_n,
  input wire output_en_n,
  input wire threshold_load_n,
  input wire sync_flag_mode_n,
  input wire fifo_reset_n,
  input wire depth_cascade_en,
  input wire [`DCFPF_DATA_W-1:0] read_data_out,
  input wire read_data_oe,
  input wire full_flag_n,
  input wire empty_flag_n,
  input wire almost_empty_flag_n,
  input wire almost_full_flag_n
);
  // ==========
  // Cycles since each pin clock rose, saturating at 15
  logic wclk_reg;
  logic rclk_reg;
  logic [3:0] w_age_reg;
  logic [3:0] r_age_reg;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wclk_reg <= 1'b0;
      rclk_reg <= 1'b0;
      w_age_reg <= 4'hF;
      r_age_reg <= 4'hF;
    end else begin
      wclk_reg <= write_clk;
      rclk_reg <= read_clk;
      w_age_reg <= (write_clk && !wclk_reg) ? 4'h0 : w_age_reg + {3'h0, w_age_reg != 4'hF};
      r_age_reg <= (read_clk && !rclk_reg) ? 4'h0 : r_age_reg + {3'h0, r_age_reg != 4'hF};
    end
  end
  // ==========
  // Assertions
  default clocking dcfpf_cb @(posedge clk); endclocking
  default disable iff (!resetn || !fifo_reset_n);
  sequence s_drive;
    !output_en_n && (!depth_cascade_en || !read_en_n);
  endsequence
  sequence s_hidden;
    depth_cascade_en && read_en_n;
  endsequence
  // Enables cross three flop stages, six steady cycles leave margin
  AST_OE_DRIVE: assert property (s_drive [*6] |-> read_data_oe) else $error("outputs not driven");
  AST_OE_FLOAT: assert property (output_en_n [*6] |-> !read_data_oe) else $error("outputs not floating");
  AST_CASCADE_HIDE: assert property (s_hidden [*6] |-> !read_data_oe) else $error("unselected device drives");
  AST_FULL_WCLK: assert property ($changed(full_flag_n) |-> w_age_reg <= 4'h3) else $error("full moved");
  AST_EMPTY_RCLK: assert property ($changed(empty_flag_n) |-> r_age_reg <= 4'h3) else $error("empty moved");
  AST_AF_SYNC: assert property (!sync_flag_mode_n && $changed(almost_full_flag_n) |-> w_age_reg <= 4'h3)
    else $error("almost full moved off write clock");
  AST_AE_SYNC: assert property (!sync_flag_mode_n && $changed(almost_empty_flag_n) |-> r_age_reg <= 4'h3)
    else $error("almost empty moved off read clock");
  AST_DATA_RCLK: assert property ($changed(read_data_out) |-> r_age_reg <= 4'h3) else $error("data moved");
  AST_EMPTY_HOLD: assert property ((!empty_flag_n && threshold_load_n) [*4] |-> $stable(read_data_out))
    else $error("empty read changed data");
  AST_EMPTY_AE: assert property (!sync_flag_mode_n && !empty_flag_n |-> !almost_empty_flag_n)
    else $error("empty without almost empty");
  AST_RESET_EMPTY: assert property (disable iff (!resetn) $fell(fifo_reset_n) |-> ##[1:4] !empty_flag_n)
    else $error("reset left fifo non-empty");
endmodule

bind dcfpf_top dcfpf_checker chk_u (.clk(clk), .resetn(resetn), .write_clk(write_clk), .read_clk(read_clk),
  .read_en_n(read_en_n), .output_en_n(output_en_n), .threshold_load_n(threshold_load_n),
  .sync_flag_mode_n(sync_flag_mode_n), .fifo_reset_n(fifo_reset_n), .depth_cascade_en(depth_cascade_en),
  .read_data_out(read_data_out), .read_data_oe(read_data_oe), .full_flag_n(full_flag_n),
  .empty_flag_n(empty_flag_n), .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n));

// file: bench/dcfpf_host.sv
// Host logic model driving the pin clocks, enables, data and replay.
// Assumes clk is the system clock; each pin high phase lasts four clk, each low phase at least five.
`timescale 1ns/10ps

module dcfpf_host (
  input wire clk,
  output logic write_clk,
  output logic read_clk,
  output logic write_en_n,
  output logic read_en_n,
  output logic [17:0] write_data_in,
  output logic threshold_load_n,
  output logic replay_pulse,
  output logic done
);
  initial begin
    write_clk = 1'b0;
    read_clk = 1'b0;
    write_en_n = 1'b1;
    read_en_n = 1'b1;
    write_data_in = 18'h00000;
    threshold_load_n = 1'b1;
    replay_pulse = 1'b0;
    done = 1'b0;
  end
  // Unwritten data shows its inverse so a stale word never looks live
  task automatic pin_cycle(input logic wen, input logic ren, input logic ld, input logic [17:0] d);
    @(posedge clk);
    write_en_n <= wen;
    read_en_n <= ren;
    threshold_load_n <= ld;
    write_data_in <= wen ? ~write_data_in : d;
    write_clk <= 1'b1;
    read_clk <= 1'b1;
    repeat (4) @(posedge clk);
    write_clk <= 1'b0;
    read_clk <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Idle cycle lets both flag domains see the opposite pointer
  task automatic op(input logic wen, input logic ren, input logic ld, input logic [17:0] d);
    pin_cycle(wen, ren, ld, d);
    pin_cycle(1'b1, 1'b1, 1'b1, 18'h00000);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask
  // Both pin clocks stay low through the pulse and the recovery
  task automatic replay();
    @(posedge clk);
    replay_pulse <= 1'b1;
    repeat (4) @(posedge clk);
    replay_pulse <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// file: bench/test_dcfpf_top.sv
// Self-checking bench for the programmable-flag FIFO.
// Assumes the host model makes pin traffic; the bench owns reset and modes.
`timescale 1ns/10ps

module test_dcfpf_top;
  logic clk, resetn, output_en_n, sync_flag_mode_n, fifo_reset_n, depth_cascade_en;
  logic write_clk, read_clk, write_en_n, read_en_n, threshold_load_n, replay_pulse, done;
  logic read_data_oe, full_flag_n, empty_flag_n, almost_empty_flag_n, almost_full_flag_n, half_full_flag_n;
  logic [17:0] write_data_in, read_data_out, last;
  logic [17:0] mem [0:63];
  logic [23:0] exp_q [$];
  logic [23:0] e;
  logic [31:0] seed;
  logic [11:0] ae_t, af_t;
  logic wsel, rsel;
  int wp, rp, i, bad_count, cmp_count;
  logic [4:0] fl;

  assign fl = {full_flag_n, empty_flag_n, almost_empty_flag_n, almost_full_flag_n, half_full_flag_n};

  dcfpf_host host_u (.clk(clk), .write_clk(write_clk), .read_clk(read_clk), .write_en_n(write_en_n),
    .read_en_n(read_en_n), .write_data_in(write_data_in), .threshold_load_n(threshold_load_n),
    .replay_pulse(replay_pulse), .done(done));
  dcfpf_top dut_u (.clk(clk), .resetn(resetn), .write_clk(write_clk), .write_en_n(write_en_n),
    .write_data_in(write_data_in), .read_clk(read_clk), .read_en_n(read_en_n), .output_en_n(output_en_n),
    .threshold_load_n(threshold_load_n), .replay_pulse(replay_pulse), .sync_flag_mode_n(sync_flag_mode_n),
    .fifo_reset_n(fifo_reset_n), .depth_cascade_en(depth_cascade_en), .read_data_out(read_data_out),
    .read_data_oe(read_data_oe), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
    .half_full_flag_n(half_full_flag_n));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [4:0] flags(input int cnt);
    return {cnt != 64, cnt != 0, cnt > ae_t, cnt + af_t < 64, cnt <= 32};
  endfunction

  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, expv, seen);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========
  // One host operation plus its expected outcome
  task automatic step(input bit w, input bit r, input bit ld, input logic [17:0] d);
    logic [31:0] x;
    x = rnd();
    if (ld) d = x[17:0];
    else d[17:12] = x[17:12];
    if (!ld && w && wsel) af_t = d[11:0];
    if (!ld && w && !wsel) ae_t = d[11:0];
    if (!ld && w) wsel = !wsel;
    if (!ld && r) last = {6'h00, rsel ? af_t : ae_t};
    if (!ld && r) rsel = !rsel;
    if (ld && w && wp - rp < 64) begin
      mem[wp % 64] = d;
      wp++;
    end
    if (ld && r && wp != rp) begin
      last = mem[rp % 64];
      rp++;
    end
    exp_q.push_back({r, last, flags(wp - rp)});
    output_en_n <= x[18];
    host_u.op(!w, !r, ld, d);
  endtask

  always @(posedge clk) begin
    if (done === 1'b1) begin
      e = exp_q.pop_front();
      check("flags", {13'h0000, fl}, {13'h0000, e[4:0]});
      // A single device here, so each composite is the AND of one flag
      check("composite", {16'h0000, &{full_flag_n}, &{empty_flag_n}}, {16'h0000, e[4:3]});
      // Read enable is high through the idle pin cycle before each check
      check("oe", {17'h00000, read_data_oe}, {17'h00000, !output_en_n && !depth_cascade_en});
      if (e[23]) check("data", read_data_out, e[22:5]);
    end
  end

  initial begin
    repeat (8000) @(posedge clk);
    bad_count++;
    $display("Error watchdog expected finish seen timeout");
    end_sim();
  end

  initial begin
    {resetn, output_en_n, sync_flag_mode_n, fifo_reset_n, depth_cascade_en} = 5'h0B;
    seed = 32'h00004400;
    {ae_t, af_t, wsel, rsel, last} = {12'h007, 12'h007, 20'h00000};
    {wp, rp, bad_count, cmp_count} = '0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    step(0, 1, 0, 18'h0);
    step(0, 1, 0, 18'h0);
    $display("test defaults done");
    step(1, 0, 0, 18'h003);
    step(1, 0, 0, 18'h005);
    step(0, 0, 0, 18'h0);
    step(1, 0, 0, 18'h004);
    step(0, 0, 1, 18'h0);
    step(1, 0, 0, 18'h006);
    for (i = 0; i < 3; i++) step(0, 1, 0, 18'h0);
    $display("test programming done");
    sync_flag_mode_n <= 1'b1;
    depth_cascade_en <= 1'b1;
    for (i = 0; i < 65; i++) step(1, 0, 1, 18'h0);
    $display("test fill done");
    sync_flag_mode_n <= 1'b0;
    depth_cascade_en <= 1'b0;
    for (i = 0; i < 66; i++) step(0, 1, 1, 18'h0);
    $display("test drain done");
    // Leave words behind so the FIFO reset has something to empty
    for (i = 0; i < 3; i++) step(1, 0, 1, 18'h0);
    fifo_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    fifo_reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    {ae_t, af_t, wsel, rsel, last, wp, rp} = {12'h007, 12'h007, 20'h00000, 64'h0};
    step(0, 1, 1, 18'h0);
    for (i = 0; i < 5; i++) step(1, 0, 1, 18'h0);
    for (i = 0; i < 2; i++) step(0, 1, 1, 18'h0);
    host_u.replay();
    rp = 0;
    step(0, 1, 0, 18'h0);
    for (i = 0; i < 5; i++) step(0, 1, 1, 18'h0);
    step(1, 0, 1, 18'h0);
    for (i = 0; i < 2; i++) step(0, 1, 1, 18'h0);
    // A cascaded device must ignore the replay, so the read stays refused
    depth_cascade_en <= 1'b1;
    host_u.replay();
    step(0, 1, 1, 18'h0);
    $display("test replay done");
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule
